// ===== mac_ctrl_pkg.sv
// shared constants, register map and carriers for the mac control block
package mac_ctrl_pkg;
  // register byte offsets
  localparam logic [7:0] CFG_OFF = 8'h00;
  localparam logic [7:0] PAUSE_OFF = 8'h04;
  localparam logic [7:0] WAKE_A_OFF = 8'h08;
  localparam logic [7:0] WAKE_B_OFF = 8'h0c;
  localparam logic [7:0] PMC_OFF = 8'h10;
  localparam logic [7:0] SRC_OFF = 8'h14;
  localparam logic [7:0] STAT_OFF = 8'h18;
  // cfg field positions
  localparam int CFG_FULL_DUPLEX = 0;
  localparam int CFG_SPEED_LO = 1;
  localparam int CFG_BACKOFF_LIMIT_SEL_LO = 3;
  localparam int CFG_RX_PAUSE = 5;
  localparam int CFG_TX_PAUSE = 6;
  localparam int CFG_FWD_PAUSE = 7;
  localparam int CFG_FORCE_PAUSE = 8;
  // pmc field positions
  localparam int PMC_LAN_WAKE = 0;
  localparam int PMC_RES_STS = 1;
  localparam int PMC_RES_EN = 2;
  localparam int PMC_SUSP_LO = 4;
  // wake source bits: exact, pattern, magic, bcast (a); v6, v4 (b)
  localparam int NSRC = 6;
  localparam logic [31:0] CFG_RESET = 32'h0000_0001;
  localparam logic [1:0] SPEED_1000 = 2'h2;
  localparam logic [1:0] SUSP_LIGHT = 2'h1;
  localparam logic [1:0] SUSP_DEEP = 2'h3;
  localparam logic [15:0] PAUSE_RESET = 16'hffff;
  // slot and quantum: 512 bit times
  localparam int SLOT_BITS = 512;
  localparam int CLK_MHZ = 250;
  localparam int SLOT_CYC_10 = SLOT_BITS * CLK_MHZ / 10;
  localparam int SLOT_CYC_100 = SLOT_BITS * CLK_MHZ / 100;
  localparam int SLOT_CYC_1000 = SLOT_BITS * CLK_MHZ / 1000;
  localparam int JAM_CYC = 32 * CLK_MHZ / 100;
  localparam int ATTEMPT_MAX = 16;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef struct packed {
    logic start;
    logic collision;
    logic late_collision;
    logic done;
  } tx_evt_t;

  typedef struct packed {
    logic pause_valid;
    logic [15:0] pause_quanta;
    logic control_frame;
    logic frame_end;
    logic [5:0] wake_hits;
  } rx_evt_t;
endpackage : mac_ctrl_pkg

// ===== mac_collision_pause_wake_control.sv
// collision, pause flow control and wake gating for the ethernet mac
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module mac_collision_pause_wake_control
  import mac_ctrl_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire tx_evt_t tx_evt_i,
  input wire logic collision_pin_i,
  input wire rx_evt_t rx_evt_i,
  input wire logic flow_on_i,
  input wire logic flow_off_i,
  input wire logic resume_i,
  output logic tx_data_allowed_o,
  output logic jam_o,
  output logic frame_replay_o,
  output logic frame_done_o,
  output logic pause_send_o,
  output logic [15:0] pause_send_time_o,
  input wire logic pause_sent_i,
  output logic rx_forward_pause_o,
  output logic rx_normal_enable_o,
  output logic rx_store_wake_frame_o,
  output logic wake_event_o,
  output logic gmii_select_o,
  output logic half_duplex_o
);
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SEND = 2'b01,
    TX_JAM = 2'b10,
    TX_BACKOFF = 2'b11
  } tx_state_t;

  logic [31:0] cfg_reg;
  logic [15:0] pause_time_reg;
  logic [NSRC-1:0] wake_en_reg;
  logic [NSRC-1:0] wake_sts_reg;
  logic [NSRC-1:0] wake_src_reg;
  logic [5:0] pmc_reg;
  tx_state_t tx_state_reg;
  logic [4:0] attempt_reg;
  logic [19:0] backoff_reg;
  logic [17:0] slot_cnt_reg;
  logic [15:0] lfsr_reg;
  logic [15:0] pause_left_reg;
  logic [15:0] pause_pend_reg;
  logic pause_pend_valid_reg;
  logic auto_armed_reg;
  logic send_req_reg;
  logic [15:0] send_time_reg;
  logic col_s1_reg, col_s2_reg;
  logic res_s1_reg, res_s2_reg, res_s3_reg;
  logic replay_reg, done_reg, wake_evt_reg, late_reg;
  logic aw_hold_reg, w_hold_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg, bresp_reg;
  logic bvalid_reg, rvalid_reg;

  logic [1:0] speed;
  logic half_duplex;
  logic [17:0] slot_cycles;
  logic slot_tick;
  logic wr_fire;
  logic resume_pulse;
  logic wake_mode;
  logic [NSRC-1:0] hits;
  logic [NSRC-1:0] en_wdata;
  logic [4:0] bo_exp;
  logic [19:0] bo_mask;

  assign speed = cfg_reg[CFG_SPEED_LO+:2];
  assign half_duplex = !cfg_reg[CFG_FULL_DUPLEX] && (speed != SPEED_1000);
  assign gmii_select_o = (speed == SPEED_1000);
  assign half_duplex_o = half_duplex;

  always_comb begin
    case (speed)
      2'h0: slot_cycles = 18'(SLOT_CYC_10);
      2'h1: slot_cycles = 18'(SLOT_CYC_100);
      default: slot_cycles = 18'(SLOT_CYC_1000);
    endcase
  end

  // free-running slot timer shared by back-off and pause countdowns
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || slot_cnt_reg >= slot_cycles - 18'h1) begin
      slot_cnt_reg <= 18'h0;
    end else begin
      slot_cnt_reg <= slot_cnt_reg + 18'h1;
    end
  end
  assign slot_tick = (slot_cnt_reg == slot_cycles - 18'h1);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      lfsr_reg <= 16'hace1;
    end else begin
      lfsr_reg <= {lfsr_reg[14:0],
                   lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
    end
  end

  // collision comes from the phy side, so synchronise it first
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      col_s1_reg <= 1'b0;
      col_s2_reg <= 1'b0;
      res_s1_reg <= 1'b0;
      res_s2_reg <= 1'b0;
      res_s3_reg <= 1'b0;
    end else begin
      col_s1_reg <= collision_pin_i;
      col_s2_reg <= col_s1_reg;
      res_s1_reg <= resume_i;
      res_s2_reg <= res_s1_reg;
      res_s3_reg <= res_s2_reg;
    end
  end
  assign resume_pulse = res_s2_reg && !res_s3_reg;

  // k = min(attempts, limit); limit field picks 10, 8, 4 or 1
  always_comb begin
    case (cfg_reg[CFG_BACKOFF_LIMIT_SEL_LO+:2])
      2'h0: bo_exp = (attempt_reg > 5'd10) ? 5'd10 : attempt_reg;
      2'h1: bo_exp = (attempt_reg > 5'd8) ? 5'd8 : attempt_reg;
      2'h2: bo_exp = (attempt_reg > 5'd4) ? 5'd4 : attempt_reg;
      default: bo_exp = (attempt_reg > 5'd1) ? 5'd1 : attempt_reg;
    endcase
    bo_mask = (20'h1 << bo_exp) - 20'h1;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      tx_state_reg <= TX_IDLE;
      attempt_reg <= 5'h0;
      backoff_reg <= 20'h0;
      replay_reg <= 1'b0;
      late_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      replay_reg <= 1'b0;
      done_reg <= 1'b0;
      case (tx_state_reg)
        TX_IDLE: begin
          if (tx_evt_i.start) begin
            tx_state_reg <= TX_SEND;
          end
        end
        TX_SEND: begin
          // in half duplex a collision halts data and jams; a late one ends the frame
          if (half_duplex && (col_s2_reg || tx_evt_i.collision ||
                              tx_evt_i.late_collision)) begin
            tx_state_reg <= TX_JAM;
            late_reg <= tx_evt_i.late_collision;
            backoff_reg <= 20'(JAM_CYC);
            attempt_reg <= attempt_reg + 5'h1;
          end else if (tx_evt_i.done) begin
            done_reg <= 1'b1;
            attempt_reg <= 5'h0;
            tx_state_reg <= TX_IDLE;
          end
        end
        TX_JAM: begin
          if (backoff_reg != 20'h0) begin
            backoff_reg <= backoff_reg - 20'h1;
          end else if (late_reg ||
                       attempt_reg >= 5'(ATTEMPT_MAX)) begin
            // abandon on excess or late collision
            done_reg <= 1'b1;
            attempt_reg <= 5'h0;
            tx_state_reg <= TX_IDLE;
          end else begin
            backoff_reg <= {4'h0, lfsr_reg} & bo_mask;
            tx_state_reg <= TX_BACKOFF;
          end
        end
        TX_BACKOFF: begin
          if (backoff_reg == 20'h0) begin
            // replay the frame from the fifo
            replay_reg <= 1'b1;
            tx_state_reg <= TX_SEND;
          end else if (slot_tick) begin
            backoff_reg <= backoff_reg - 20'h1;
          end
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end
  assign jam_o = (tx_state_reg == TX_JAM) && (backoff_reg != 20'h0);
  assign frame_replay_o = replay_reg;
  assign frame_done_o = done_reg;

  // pause request latched with quanta value
  // held pending while a frame is in flight
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pause_pend_valid_reg <= 1'b0;
      pause_pend_reg <= 16'h0;
      pause_left_reg <= 16'h0;
    end else begin
      if (rx_evt_i.pause_valid && cfg_reg[CFG_RX_PAUSE]) begin
        pause_pend_valid_reg <= 1'b1;
        pause_pend_reg <= rx_evt_i.pause_quanta;
      end else if (pause_pend_valid_reg && tx_state_reg == TX_IDLE) begin
        pause_pend_valid_reg <= 1'b0;
      end
      if (pause_pend_valid_reg && tx_state_reg == TX_IDLE) begin
        pause_left_reg <= pause_pend_reg;
      end else if (slot_tick && pause_left_reg != 16'h0) begin
        pause_left_reg <= pause_left_reg - 16'h1;
      end
    end
  end
  // data frame starts blocked while paused
  assign tx_data_allowed_o = (pause_left_reg == 16'h0) &&
                             !(pause_pend_valid_reg &&
                               tx_state_reg == TX_IDLE);
  // control frames kept unless forwarding is on
  assign rx_forward_pause_o = cfg_reg[CFG_FWD_PAUSE];

  // force, automatic on and off pause
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      send_req_reg <= 1'b0;
      send_time_reg <= 16'h0;
      auto_armed_reg <= 1'b1;
    end else begin
      if (send_req_reg && pause_sent_i) begin
        send_req_reg <= 1'b0;
      end
      if (wr_fire && aw_addr_reg == CFG_OFF && w_strb_reg[1] &&
          w_data_reg[CFG_FORCE_PAUSE]) begin
        send_req_reg <= 1'b1;
        send_time_reg <= pause_time_reg;
      end else if (cfg_reg[CFG_TX_PAUSE] && flow_on_i && auto_armed_reg) begin
        send_req_reg <= 1'b1;
        send_time_reg <= pause_time_reg;
        auto_armed_reg <= 1'b0;
      end else if (cfg_reg[CFG_TX_PAUSE] && flow_off_i && !auto_armed_reg) begin
        send_req_reg <= 1'b1;
        send_time_reg <= 16'h0;
        auto_armed_reg <= 1'b1;
      end
    end
  end
  assign pause_send_o = send_req_reg;
  assign pause_send_time_o = send_time_reg;

  // wake gating on global enable, any source enable and light or deep suspend
  assign wake_mode = pmc_reg[PMC_LAN_WAKE] && (|wake_en_reg) &&
                     (pmc_reg[PMC_SUSP_LO+:2] == SUSP_LIGHT ||
                      pmc_reg[PMC_SUSP_LO+:2] == SUSP_DEEP);
  assign hits = rx_evt_i.frame_end && wake_mode ?
                (rx_evt_i.wake_hits & wake_en_reg) : '0;
  // normal receive off while any enable is set
  assign rx_normal_enable_o = ~|wake_en_reg;
  // keep the triggering frame in deep suspend
  assign rx_store_wake_frame_o = (|hits) &&
                                 (pmc_reg[PMC_SUSP_LO+:2] == SUSP_DEEP);

  // enable write lanes: a takes data[3:0], b takes data[1:0]
  assign en_wdata = {w_data_reg[1:0], w_data_reg[3:0]};
  // wake status: hardware set wins over software clear
  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi++) begin : g_wake
      always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
          wake_sts_reg[gi] <= 1'b0;
          wake_src_reg[gi] <= 1'b0;
          wake_en_reg[gi] <= 1'b0;
        end else begin
          if (hits[gi]) begin
            wake_sts_reg[gi] <= 1'b1;
          end else if (resume_pulse && pmc_reg[PMC_RES_STS]) begin
            wake_sts_reg[gi] <= 1'b0;
          end else if (wr_fire && w_strb_reg[0] &&
                       ((gi < 4 && aw_addr_reg == WAKE_A_OFF &&
                         w_data_reg[gi+4]) ||
                        (gi >= 4 && aw_addr_reg == WAKE_B_OFF &&
                         w_data_reg[gi])))
          begin
            wake_sts_reg[gi] <= 1'b0;
          end
          if (|hits) begin
            wake_src_reg[gi] <= hits[gi];
          end
          if (resume_pulse && pmc_reg[PMC_RES_EN]) begin
            wake_en_reg[gi] <= 1'b0;
          end else if (wr_fire && w_strb_reg[0] && gi < 4 &&
                       aw_addr_reg == WAKE_A_OFF) begin
            wake_en_reg[gi] <= en_wdata[gi];
          end else if (wr_fire && w_strb_reg[0] && gi >= 4 &&
                       aw_addr_reg == WAKE_B_OFF) begin
            wake_en_reg[gi] <= en_wdata[gi];
          end
        end
      end
    end
  endgenerate

  // one-cycle wake event to the host side
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wake_evt_reg <= 1'b0;
    end else begin
      wake_evt_reg <= |hits;
    end
  end
  assign wake_event_o = wake_evt_reg;

  // axi4-lite write: address and data may arrive in either order
  assign s_axi_awready_o = !aw_hold_reg && !s_axi_bvalid_o;
  assign s_axi_wready_o = !w_hold_reg && !s_axi_bvalid_o;
  assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= AXI_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr_i[7:2], 2'h0};
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_i;
        w_strb_reg <= s_axi_wstrb_i;
      end
      if (wr_fire) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= (aw_addr_reg <= STAT_OFF) ? AXI_OKAY : AXI_SLVERR;
      end else if (bvalid_reg && s_axi_bready_i) begin
        bvalid_reg <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;

  // config registers; force bit is self-clearing so never stored
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cfg_reg <= CFG_RESET;
      pause_time_reg <= PAUSE_RESET;
      pmc_reg <= 6'h0;
    end else if (wr_fire) begin
      if (aw_addr_reg == CFG_OFF && w_strb_reg[0]) begin
        cfg_reg[7:0] <= w_data_reg[7:0];
      end
      if (aw_addr_reg == PAUSE_OFF && w_strb_reg[0]) begin
        pause_time_reg[7:0] <= w_data_reg[7:0];
      end
      if (aw_addr_reg == PAUSE_OFF && w_strb_reg[1]) begin
        pause_time_reg[15:8] <= w_data_reg[15:8];
      end
      if (aw_addr_reg == PMC_OFF && w_strb_reg[0]) begin
        pmc_reg <= w_data_reg[5:0];
      end
    end
  end

  assign s_axi_arready_o = !rvalid_reg;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= AXI_OKAY;
    end else if (s_axi_arvalid_i && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= AXI_OKAY;
      case ({s_axi_araddr_i[7:2], 2'h0})
        CFG_OFF: rdata_reg <= {23'h0, 1'b0, cfg_reg[7:0]};
        PAUSE_OFF: rdata_reg <= {16'h0, pause_time_reg};
        WAKE_A_OFF: rdata_reg <= {24'h0, wake_sts_reg[3:0],
                                  wake_en_reg[3:0]};
        WAKE_B_OFF: rdata_reg <= {24'h0, wake_sts_reg[5:4], 2'h0,
                                  2'h0, wake_en_reg[5:4]};
        PMC_OFF: rdata_reg <= {26'h0, pmc_reg};
        SRC_OFF: rdata_reg <= {26'h0, wake_src_reg};
        STAT_OFF: rdata_reg <= {9'h0, auto_armed_reg, tx_state_reg,
                                pause_left_reg, attempt_reg[3:0]};
        default: begin
          rdata_reg <= 32'h0;
          rresp_reg <= AXI_SLVERR;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready_i) begin
      rvalid_reg <= 1'b0;
    end
  end
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign s_axi_rresp_o = rresp_reg;
endmodule : mac_collision_pause_wake_control

// ===== mac_ctrl_assertions.sv
// concurrent checks on the mac control block ports
`timescale 1ns/1ps
module mac_ctrl_checker
  import mac_ctrl_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire rx_evt_t rx_evt_i,
  input wire logic jam_o,
  input wire logic frame_replay_o,
  input wire logic frame_done_o,
  input wire logic pause_send_o,
  input wire logic [15:0] pause_send_time_o,
  input wire logic pause_sent_i,
  input wire logic rx_normal_enable_o,
  input wire logic rx_store_wake_frame_o,
  input wire logic wake_event_o,
  input wire logic gmii_select_o,
  input wire logic half_duplex_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0] jam_len_reg;
  // length of the running jam burst, saturating so it never wraps
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !jam_o) begin
      jam_len_reg <= 8'h00;
    end else if (jam_len_reg != 8'hff) begin
      jam_len_reg <= jam_len_reg + 8'h01;
    end
  end
  property p_jam_len;
    $fell(jam_o) |-> jam_len_reg == JAM_CYC;
  endproperty
  a_jam_len: assert property (p_jam_len)
    else $error("jam burst length wrong");
  property p_gig_full;
    gmii_select_o |-> !half_duplex_o;
  endproperty
  a_gig_full: assert property (p_gig_full)
    else $error("half duplex on gigabit path");
  property p_replay;
    frame_replay_o |-> !jam_o ##1 !frame_replay_o;
  endproperty
  a_replay: assert property (p_replay)
    else $error("replay pulse malformed");
  property p_done;
    frame_done_o |=> !frame_done_o;
  endproperty
  a_done: assert property (p_done)
    else $error("done pulse longer than one cycle");
  property p_pause_hold;
    pause_send_o && !pause_sent_i |=>
      pause_send_o && $stable(pause_send_time_o);
  endproperty
  a_pause_hold: assert property (p_pause_hold)
    else $error("pause request dropped or changed early");
  property p_pause_drop;
    pause_send_o && pause_sent_i |=> !pause_send_o;
  endproperty
  a_pause_drop: assert property (p_pause_drop)
    else $error("pause request held after accept");
  property p_wake_cause;
    wake_event_o |-> $past(rx_evt_i.frame_end) &&
      $past(rx_evt_i.wake_hits) != 6'h00 ##1 !wake_event_o;
  endproperty
  a_wake_cause: assert property (p_wake_cause)
    else $error("wake event without a hit");
  property p_wake_mode;
    wake_event_o |-> !$past(rx_normal_enable_o);
  endproperty
  a_wake_mode: assert property (p_wake_mode)
    else $error("wake event while reception normal");
  property p_store;
    rx_store_wake_frame_o |-> rx_evt_i.frame_end &&
      !rx_normal_enable_o && rx_evt_i.wake_hits != 6'h00;
  endproperty
  a_store: assert property (p_store)
    else $error("wake frame stored without a hit");
endmodule : mac_ctrl_checker

bind mac_collision_pause_wake_control mac_ctrl_checker
  mac_ctrl_checker_inst (.*);

// ===== mac_far_side_model.sv
// far side model: transmit path that accepts pause frames
`timescale 1ns/1ps
module mac_far_side_model (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic pause_req_i,
  input wire logic [15:0] pause_time_i,
  output logic pause_ack_o,
  output logic [15:0] last_time_o,
  output logic [7:0] count_o
);
  logic [4:0] wait_reg;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pause_ack_o <= 1'b0;
      wait_reg <= 5'h00;
      last_time_o <= 16'h0000;
      count_o <= 8'h00;
    end else begin
      pause_ack_o <= 1'b0;
      if (!pause_req_i || pause_ack_o) begin
        wait_reg <= 5'h00;
      end else if (wait_reg >= (slow_i ? 5'h13 : 5'h00)) begin
        pause_ack_o <= 1'b1;
        last_time_o <= pause_time_i;
        count_o <= count_o + 8'h01;
        wait_reg <= 5'h00;
      end else begin
        wait_reg <= wait_reg + 5'h01;
      end
    end
  end
endmodule : mac_far_side_model

// ===== mac_collision_pause_wake_control_tb_top.sv
// self-checking bench for the mac control block
`timescale 1ns/1ps
module mac_collision_pause_wake_control_tb_top;
  import mac_ctrl_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, rd;
  logic [3:0] s_axi_wstrb_i;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, resp;
  logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
  logic s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o;
  logic s_axi_rvalid_o, s_axi_rready_i, st, far_slow;
  tx_evt_t tx_evt_i;
  rx_evt_t rx_evt_i;
  logic collision_pin_i, flow_on_i, flow_off_i, resume_i, pause_sent_i;
  logic tx_data_allowed_o, jam_o, frame_replay_o, frame_done_o;
  logic pause_send_o, rx_forward_pause_o, rx_normal_enable_o;
  logic rx_store_wake_frame_o, wake_event_o, gmii_select_o, half_duplex_o;
  logic [15:0] pause_send_time_o, far_time;
  logic [7:0] far_count;
  int err_count = 0;
  int num_checks = 0;
  int n;
  localparam int SLOT = SLOT_CYC_100;

  mac_collision_pause_wake_control mac_collision_pause_wake_control_inst (.*);
  mac_far_side_model mac_far_side_model_inst (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .slow_i(far_slow),
    .pause_req_i(pause_send_o), .pause_time_i(pause_send_time_o),
    .pause_ack_o(pause_sent_i), .last_time_o(far_time),
    .count_o(far_count));

  always #2 sys_clk_i = ~sys_clk_i;

  task tally_and_finish;
    if (err_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish

  task check(input string what, input logic [31:0] seen,
             input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task hang(input string what);
    err_count++;
    $display("mismatch %s expected answer seen timeout", what);
    tally_and_finish();
  endtask : hang

  // handshakes are judged at the negedge and acted on at the next edge
  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    @(posedge sys_clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    for (int i = 0; i < 100; i++) begin
      @(negedge sys_clk_i);
      aw = s_axi_awvalid_i && s_axi_awready_o;
      w = s_axi_wvalid_i && s_axi_wready_o;
      b = s_axi_bvalid_o;
      resp = s_axi_bresp_o;
      @(posedge sys_clk_i);
      if (aw) s_axi_awvalid_i <= 1'b0;
      if (w) s_axi_wvalid_i <= 1'b0;
      if (b) begin
        s_axi_bready_i <= 1'b0;
        return;
      end
    end
    hang("axi write");
  endtask : axi_wr

  task axi_rd(input logic [7:0] a);
    logic ar, r;
    @(posedge sys_clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    for (int i = 0; i < 100; i++) begin
      @(negedge sys_clk_i);
      ar = s_axi_arvalid_i && s_axi_arready_o;
      r = s_axi_rvalid_o;
      rd = s_axi_rdata_o;
      resp = s_axi_rresp_o;
      @(posedge sys_clk_i);
      if (ar) s_axi_arvalid_i <= 1'b0;
      if (r) begin
        s_axi_rready_i <= 1'b0;
        return;
      end
    end
    hang("axi read");
  endtask : axi_rd

  function logic pick(input int sel);
    case (sel)
      0: return jam_o;
      1: return !jam_o;
      2: return frame_replay_o;
      3: return frame_done_o;
      4: return !tx_data_allowed_o;
      5: return tx_data_allowed_o;
      6: return wake_event_o;
      7: return pause_send_o && pause_sent_i;
      default: return pause_send_o;
    endcase
  endfunction : pick

  task await(input int sel, input int lim);
    for (n = 0; n < lim; n++) begin
      @(negedge sys_clk_i);
      if (pick(sel) === 1'b1) return;
    end
    hang("await");
  endtask : await

  task quiet(input int sel, input int lim, input string what);
    logic seen;
    seen = 1'b0;
    repeat (lim) begin
      @(negedge sys_clk_i);
      seen = seen | pick(sel);
    end
    check(what, seen, 1'b0);
  endtask : quiet

  task tx_pulse(input tx_evt_t e);
    @(posedge sys_clk_i);
    tx_evt_i <= e;
    @(posedge sys_clk_i);
    tx_evt_i <= '0;
  endtask : tx_pulse

  task rx_pulse(input logic pv, input logic [15:0] q, input logic [5:0] h);
    @(posedge sys_clk_i);
    rx_evt_i <= '{pv, q, pv, !pv, h};
    @(negedge sys_clk_i);
    st = rx_store_wake_frame_o;
    @(posedge sys_clk_i);
    rx_evt_i <= '0;
  endtask : rx_pulse

  task flow(input logic on);
    @(posedge sys_clk_i);
    flow_on_i <= on;
    flow_off_i <= !on;
    @(posedge sys_clk_i);
    flow_on_i <= 1'b0;
    flow_off_i <= 1'b0;
    await(7, 40);
    @(negedge sys_clk_i);
  endtask : flow

  initial begin
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = '0;
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = 3'h0;
    {s_axi_arvalid_i, s_axi_rready_i, far_slow} = 3'h0;
    s_axi_wstrb_i = 4'hf;
    tx_evt_i = '0;
    rx_evt_i = '0;
    {collision_pin_i, flow_on_i, flow_off_i, resume_i} = 4'h0;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    axi_rd(CFG_OFF);
    check("cfg reset", rd, CFG_RESET);
    axi_rd(PAUSE_OFF);
    check("pause reset", rd, {16'h0000, PAUSE_RESET});
    axi_rd(8'h1c);
    check("unmapped read", {resp, rd}, {AXI_SLVERR, 32'h0});
    axi_wr(8'h20, 32'h0);
    check("unmapped write", resp, AXI_SLVERR);
    axi_wr(CFG_OFF, 32'h4);
    check("gmii", gmii_select_o, 1'b1);
    check("half at gig", half_duplex_o, 1'b0);
    axi_wr(CFG_OFF, 32'h1a);
    check("mii", {gmii_select_o, half_duplex_o}, 2'h1);
    tx_pulse(4'h8);
    @(posedge sys_clk_i);
    collision_pin_i <= 1'b1;
    await(0, 20);
    @(posedge sys_clk_i);
    collision_pin_i <= 1'b0;
    await(1, 100);
    check("jam length", n, JAM_CYC - 1);
    await(2, 3 * SLOT);
    check("backoff", n <= 2 * SLOT + 8, 1'b1);
    tx_pulse(4'h8);
    tx_pulse(4'h2);
    await(3, 200);
    tx_pulse(4'h8);
    tx_pulse(4'h1);
    await(3, 4);
    check("done delay", n <= 1, 1'b1);
    axi_wr(CFG_OFF, 32'ha3);
    check("forward on", rx_forward_pause_o, 1'b1);
    tx_pulse(4'h8);
    rx_pulse(1'b1, 16'h0002, 6'h00);
    axi_rd(STAT_OFF);
    check("pause mid frame", rd[19:4], 16'h0000);
    tx_pulse(4'h1);
    await(4, 20);
    await(5, 3 * SLOT);
    check("pause span", n > SLOT && n <= 2 * SLOT + 8, 1'b1);
    axi_wr(PAUSE_OFF, 32'h1234);
    @(posedge sys_clk_i);
    far_slow <= 1'b1;
    axi_wr(CFG_OFF, 32'h123);
    await(7, 60);
    @(negedge sys_clk_i);
    check("forced time", {far_count, far_time}, 24'h011234);
    check("forward off", rx_forward_pause_o, 1'b0);
    axi_rd(CFG_OFF);
    check("force clears", rd, 32'h23);
    far_slow <= 1'b0;
    axi_wr(CFG_OFF, 32'h63);
    flow(1'b1);
    check("on time", far_time, 16'h1234);
    @(posedge sys_clk_i);
    flow_on_i <= 1'b1;
    @(posedge sys_clk_i);
    flow_on_i <= 1'b0;
    quiet(8, 20, "second on");
    flow(1'b0);
    check("off time", far_time, 16'h0000);
    flow(1'b1);
    check("rearmed", {far_count, far_time}, 24'h041234);
    axi_wr(CFG_OFF, 32'h23);
    @(posedge sys_clk_i);
    flow_off_i <= 1'b1;
    @(posedge sys_clk_i);
    flow_off_i <= 1'b0;
    quiet(8, 20, "auto disabled");
    axi_wr(WAKE_A_OFF, 32'h9);
    axi_wr(PMC_OFF, 32'h16);
    rx_pulse(1'b0, 16'h0000, 6'h09);
    quiet(6, 5, "wake gated");
    axi_wr(PMC_OFF, 32'h17);
    check("rx blocked", rx_normal_enable_o, 1'b0);
    rx_pulse(1'b0, 16'h0000, 6'h09);
    check("store light", st, 1'b0);
    await(6, 3);
    axi_rd(WAKE_A_OFF);
    check("wake status", rd, 32'h99);
    @(posedge sys_clk_i);
    resume_i <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    resume_i <= 1'b0;
    axi_rd(WAKE_A_OFF);
    check("resume clears", rd, 32'h0);
    check("rx normal", rx_normal_enable_o, 1'b1);
    axi_rd(SRC_OFF);
    check("source kept", rd, 32'h09);
    axi_wr(WAKE_B_OFF, 32'h2);
    axi_wr(PMC_OFF, 32'h31);
    rx_pulse(1'b0, 16'h0000, 6'h20);
    check("store deep", st, 1'b1);
    await(6, 3);
    axi_rd(SRC_OFF);
    check("source v4", rd, 32'h20);
    axi_wr(WAKE_B_OFF, 32'h30);
    axi_rd(WAKE_B_OFF);
    check("host clear", rd, 32'h0);
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    @(posedge sys_clk_i);
    rst_i <= 1'b0;
    axi_rd(CFG_OFF);
    check("cfg second reset", rd, CFG_RESET);
    tally_and_finish();
  end
endmodule : mac_collision_pause_wake_control_tb_top
